/* rtl/hhclk_top.sv */
// time-of-day clock with alarm, top level
//
// Functional notes
// - hours 0..23, minutes 0..59
// - time setup keys bump current time
// - alarm setup keys bump alarm time
// - all counters wrap to zero past max
// - tick period configurable, default 10 ms
// - chained seconds, minutes, hours counters
// - wrap emits carry to next stage
// - two setup pulses for current time
// - dedicated alarm counters, key driven only
// - alarm when hours and minutes equal, once armed after reset
// - seconds driven by 1 Hz square wave
// - stage changes only on rising input
// - hour clears at 23, clear is carry
// - max flag captured on falling edge
// - no increment while clearing
// - increment is chain OR setup
// - byte-wide count outputs
// - alarm counters use simpler clear feedback
`timescale 1ns/100ps
module hhclk_top #(
   parameter int unsigned TICK_CYCLES = hhclk_pkg::TICK_CYCLES
) (
   input  wire logic       CORE_CLK,
   input  wire logic       RST_B,
   input  wire logic       KEY_TIME_SET,
   input  wire logic       KEY_ALARM_SET,
   input  wire logic       KEY_HOUR,
   input  wire logic       KEY_MINUTE,
   output logic [7:0]      SECONDS,
   output logic [7:0]      MINUTES,
   output logic [7:0]      HOURS,
   output logic [7:0]      ALARM_MINUTES,
   output logic [7:0]      ALARM_HOURS,
   output logic            ALARM
);
   logic       wave;
   logic       hour_d_reg;
   logic       min_d_reg;
   logic       hour_pulse_reg;
   logic       min_pulse_reg;
   logic       set_tmin;
   logic       set_thour;
   logic       set_amin;
   logic       set_ahour;
   logic       sec_carry;
   logic       min_carry;
   logic [7:0] sec_cnt;
   logic [7:0] min_cnt;
   logic [7:0] hour_cnt;
   logic [7:0] amin_cnt;
   logic [7:0] ahour_cnt;

   hhclk_timebase #(
      .TICK_CYCLES (TICK_CYCLES),
      .HALF_TICKS  (hhclk_pkg::TICKS_PER_HALF)
   ) u_tb (
      .clk      (CORE_CLK),
      .rst_b    (RST_B),
      .wave_reg (wave)
   );

   always_ff @(posedge CORE_CLK or negedge RST_B) begin
      if (!RST_B) begin
         hour_d_reg     <= 1'b0;
         min_d_reg      <= 1'b0;
         hour_pulse_reg <= 1'b0;
         min_pulse_reg  <= 1'b0;
      end else begin
         hour_d_reg     <= KEY_HOUR;
         min_d_reg      <= KEY_MINUTE;
         hour_pulse_reg <= KEY_HOUR & ~hour_d_reg;
         min_pulse_reg  <= KEY_MINUTE & ~min_d_reg;
      end
   end

   assign set_tmin  = KEY_TIME_SET & min_pulse_reg;
   assign set_thour = KEY_TIME_SET & hour_pulse_reg;
   // alarm setup pulses; time setup takes priority if both held
   assign set_amin  = KEY_ALARM_SET & ~KEY_TIME_SET & min_pulse_reg;
   assign set_ahour = KEY_ALARM_SET & ~KEY_TIME_SET & hour_pulse_reg;

   hhclk_unit #(.MAXV(hhclk_pkg::SEC_MAX), .STRICT(1'b1)) u_sec (
      .clk       (CORE_CLK),
      .rst_b     (RST_B),
      .chain_in  (wave),
      .setup_in  (1'b0),
      .count_reg (sec_cnt),
      .carry_reg (sec_carry)
   );
   hhclk_unit #(.MAXV(hhclk_pkg::MIN_MAX), .STRICT(1'b1)) u_min (
      .clk       (CORE_CLK),
      .rst_b     (RST_B),
      .chain_in  (sec_carry),
      .setup_in  (set_tmin),
      .count_reg (min_cnt),
      .carry_reg (min_carry)
   );
   hhclk_unit #(.MAXV(hhclk_pkg::HOUR_MAX), .STRICT(1'b1)) u_hour (
      .clk       (CORE_CLK),
      .rst_b     (RST_B),
      .chain_in  (min_carry),
      .setup_in  (set_thour),
      .count_reg (hour_cnt),
      .carry_reg ()
   );
   hhclk_unit #(.MAXV(hhclk_pkg::MIN_MAX), .STRICT(1'b0)) u_amin (
      .clk       (CORE_CLK),
      .rst_b     (RST_B),
      .chain_in  (1'b0),
      .setup_in  (set_amin),
      .count_reg (amin_cnt),
      .carry_reg ()
   );
   hhclk_unit #(.MAXV(hhclk_pkg::HOUR_MAX), .STRICT(1'b0)) u_ahour (
      .clk       (CORE_CLK),
      .rst_b     (RST_B),
      .chain_in  (1'b0),
      .setup_in  (set_ahour),
      .count_reg (ahour_cnt),
      .carry_reg ()
   );

   always_ff @(posedge CORE_CLK or negedge RST_B) begin
      if (!RST_B) begin
         SECONDS       <= hhclk_pkg::COUNT_RESET;
         MINUTES       <= hhclk_pkg::COUNT_RESET;
         HOURS         <= hhclk_pkg::COUNT_RESET;
         ALARM_MINUTES <= hhclk_pkg::COUNT_RESET;
         ALARM_HOURS   <= hhclk_pkg::COUNT_RESET;
      end else begin
         SECONDS       <= sec_cnt;
         MINUTES       <= min_cnt;
         HOURS         <= hour_cnt;
         ALARM_MINUTES <= amin_cnt;
         ALARM_HOURS   <= ahour_cnt;
      end
   end

   // alarm level while time matches; after reset 00:00 matches
   // so it is masked until the seconds first wrap or the alarm was set
   logic armed_reg;
   always_ff @(posedge CORE_CLK or negedge RST_B) begin
      if (!RST_B) begin
         armed_reg <= 1'b0;
      end else if (set_amin || set_ahour || sec_carry) begin
         armed_reg <= 1'b1;
      end
   end

   always_ff @(posedge CORE_CLK or negedge RST_B) begin
      if (!RST_B) begin
         ALARM <= 1'b0;
      end else begin
         ALARM <= armed_reg && (hour_cnt == ahour_cnt) && (min_cnt == amin_cnt);
      end
   end

   a_alarm_match: assert property (@(posedge CORE_CLK) disable iff (!RST_B)
      (armed_reg && hour_cnt == ahour_cnt && min_cnt == amin_cnt) |=> ALARM)
      else $error("alarm missed on match");
   a_alarm_nomatch: assert property (@(posedge CORE_CLK) disable iff (!RST_B)
      (hour_cnt != ahour_cnt || min_cnt != amin_cnt) |=> !ALARM)
      else $error("alarm without match");
   a_alarm_isolate: assert property (@(posedge CORE_CLK) disable iff (!RST_B)
      (!set_amin && !set_ahour) |=> $stable(amin_cnt) && $stable(ahour_cnt))
      else $error("alarm time changed without keys");
   a_key_pulse: assert property (@(posedge CORE_CLK) disable iff (!RST_B)
      min_pulse_reg |=> !min_pulse_reg)
      else $error("key pulse longer than one cycle");
   a_min_setup: assert property (@(posedge CORE_CLK) disable iff (!RST_B)
      (set_tmin && !sec_carry && min_cnt < hhclk_pkg::MIN_MAX) ##1 !$past(min_carry)
      |-> ##1 min_cnt == $past(min_cnt, 2) + 8'h01)
      else $error("minute setup did not add one");
   a_hour_carry: assert property (@(posedge CORE_CLK) disable iff (!RST_B)
      $rose(min_carry) && !set_thour && hour_cnt < hhclk_pkg::HOUR_MAX
      |=> hour_cnt == $past(hour_cnt) + 8'h01)
      else $error("carry did not advance hours");

   a_sec_range: assert property (@(posedge CORE_CLK) disable iff (!RST_B)
      SECONDS <= hhclk_pkg::SEC_MAX)
      else $error("seconds out of range");
   a_min_range: assert property (@(posedge CORE_CLK) disable iff (!RST_B)
      MINUTES <= hhclk_pkg::MIN_MAX)
      else $error("minutes out of range");
   a_hour_range: assert property (@(posedge CORE_CLK) disable iff (!RST_B)
      HOURS <= hhclk_pkg::HOUR_MAX)
      else $error("hours out of range");
   a_amin_range: assert property (@(posedge CORE_CLK) disable iff (!RST_B)
      ALARM_MINUTES <= hhclk_pkg::MIN_MAX)
      else $error("alarm minutes out of range");
   a_ahour_range: assert property (@(posedge CORE_CLK) disable iff (!RST_B)
      ALARM_HOURS <= hhclk_pkg::HOUR_MAX)
      else $error("alarm hours out of range");

   a_sec_out: assert property (@(posedge CORE_CLK) disable iff (!RST_B)
      1'b1 |=> SECONDS == $past(sec_cnt))
      else $error("seconds output does not follow stage");
   a_min_out: assert property (@(posedge CORE_CLK) disable iff (!RST_B)
      1'b1 |=> MINUTES == $past(min_cnt))
      else $error("minutes output does not follow stage");
   a_hour_out: assert property (@(posedge CORE_CLK) disable iff (!RST_B)
      1'b1 |=> HOURS == $past(hour_cnt))
      else $error("hours output does not follow stage");
   a_amin_out: assert property (@(posedge CORE_CLK) disable iff (!RST_B)
      1'b1 |=> ALARM_MINUTES == $past(amin_cnt))
      else $error("alarm minutes output does not follow stage");
   a_ahour_out: assert property (@(posedge CORE_CLK) disable iff (!RST_B)
      1'b1 |=> ALARM_HOURS == $past(ahour_cnt))
      else $error("alarm hours output does not follow stage");

   a_amin_step: assert property (@(posedge CORE_CLK) disable iff (!RST_B)
      (set_amin && amin_cnt < hhclk_pkg::MIN_MAX) |=> amin_cnt == $past(amin_cnt) + 8'h01)
      else $error("alarm minute setup did not add one");
   a_ahour_step: assert property (@(posedge CORE_CLK) disable iff (!RST_B)
      (set_ahour && ahour_cnt < hhclk_pkg::HOUR_MAX) |=> ahour_cnt == $past(ahour_cnt) + 8'h01)
      else $error("alarm hour setup did not add one");
   a_amin_wrap: assert property (@(posedge CORE_CLK) disable iff (!RST_B)
      (set_amin && amin_cnt == hhclk_pkg::MIN_MAX) |=> amin_cnt == hhclk_pkg::COUNT_RESET)
      else $error("alarm minutes did not wrap");
   a_ahour_wrap: assert property (@(posedge CORE_CLK) disable iff (!RST_B)
      (set_ahour && ahour_cnt == hhclk_pkg::HOUR_MAX) |=> ahour_cnt == hhclk_pkg::COUNT_RESET)
      else $error("alarm hours did not wrap");

   a_hour_pulse: assert property (@(posedge CORE_CLK) disable iff (!RST_B)
      hour_pulse_reg |=> !hour_pulse_reg)
      else $error("hour key pulse longer than one cycle");
   a_sec_carry: assert property (@(posedge CORE_CLK) disable iff (!RST_B)
      $rose(sec_carry) |-> sec_cnt == hhclk_pkg::COUNT_RESET)
      else $error("seconds carry without wrap");
   a_min_carry: assert property (@(posedge CORE_CLK) disable iff (!RST_B)
      $rose(min_carry) |-> min_cnt == hhclk_pkg::COUNT_RESET)
      else $error("minutes carry without wrap");
   a_hour_wrap: assert property (@(posedge CORE_CLK) disable iff (!RST_B)
      ($rose(min_carry) && !set_thour && !$past(set_thour) && hour_cnt == hhclk_pkg::HOUR_MAX)
      |=> hour_cnt == hhclk_pkg::COUNT_RESET)
      else $error("hours did not clear at max");
   a_alarm_mask: assert property (@(posedge CORE_CLK) disable iff (!RST_B)
      !armed_reg |=> !ALARM)
      else $error("alarm raised while masked");

   a_sec_hold: assert property (@(posedge CORE_CLK) disable iff (!RST_B)
      $stable(wave) |=> $stable(sec_cnt))
      else $error("seconds changed without wave edge");
   a_min_hold: assert property (@(posedge CORE_CLK) disable iff (!RST_B)
      ($stable(sec_carry) && !set_tmin && !$past(set_tmin)) |=> $stable(min_cnt))
      else $error("minutes changed without input edge");
   a_hour_hold: assert property (@(posedge CORE_CLK) disable iff (!RST_B)
      ($stable(min_carry) && !set_thour && !$past(set_thour)) |=> $stable(hour_cnt))
      else $error("hours changed without input edge");
   a_thour_step: assert property (@(posedge CORE_CLK) disable iff (!RST_B)
      (set_thour && !min_carry && !$past(min_carry) && !$past(set_thour) && hour_cnt < hhclk_pkg::HOUR_MAX)
      |=> hour_cnt == $past(hour_cnt) + 8'h01)
      else $error("hour setup did not add one");
   a_sec_step: assert property (@(posedge CORE_CLK) disable iff (!RST_B)
      ($rose(wave) && sec_cnt < hhclk_pkg::SEC_MAX) |=> sec_cnt == $past(sec_cnt) + 8'h01)
      else $error("wave rise did not add a second");

   c_alarm_fires: cover property (@(posedge CORE_CLK) disable iff (!RST_B) $rose(ALARM));
   c_hour_wrap: cover property (@(posedge CORE_CLK) disable iff (!RST_B)
      hour_cnt == hhclk_pkg::HOUR_MAX ##1 hour_cnt == hhclk_pkg::COUNT_RESET);
   c_alarm_set: cover property (@(posedge CORE_CLK) disable iff (!RST_B) set_ahour);
   c_time_setup: cover property (@(posedge CORE_CLK) disable iff (!RST_B) set_tmin);
   c_min_carry: cover property (@(posedge CORE_CLK) disable iff (!RST_B) $rose(min_carry));
endmodule

/* rtl/hhclk_pkg.sv */
// constants shared by the time-of-day clock with alarm
package hhclk_pkg;
   localparam int unsigned CLK_HZ        = 25_000_000;
   localparam int unsigned TICK_MS       = 10;
   localparam int unsigned TICK_CYCLES   = (CLK_HZ / 1000) * TICK_MS;
   localparam int unsigned HALF_SEC_MS   = 500;
   localparam int unsigned TICKS_PER_HALF = HALF_SEC_MS / TICK_MS;
   localparam logic [7:0]  SEC_MAX       = 8'h3B;
   localparam logic [7:0]  MIN_MAX       = 8'h3B;
   localparam logic [7:0]  HOUR_MAX      = 8'h17;
   localparam logic [7:0]  COUNT_RESET   = 8'h00;
endpackage

/* rtl/hhclk_timebase.sv */
// periodic tick and one-hertz square wave
`timescale 1ns/100ps
module hhclk_timebase #(
   parameter int unsigned TICK_CYCLES = hhclk_pkg::TICK_CYCLES,
   parameter int unsigned HALF_TICKS  = hhclk_pkg::TICKS_PER_HALF
) (
   input  wire logic clk,
   input  wire logic rst_b,
   output logic      wave_reg
);
   logic [31:0] div_reg;
   logic [31:0] half_reg;
   logic        tick;

   assign tick = (div_reg == 32'(TICK_CYCLES - 1));

   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         div_reg <= 32'h0000_0000;
      end else if (tick) begin
         div_reg <= 32'h0000_0000;
      end else begin
         div_reg <= div_reg + 32'h0000_0001;
      end
   end

   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         half_reg <= 32'h0000_0000;
         wave_reg <= 1'b0;
      end else if (tick) begin
         if (half_reg == 32'(HALF_TICKS - 1)) begin
            half_reg <= 32'h0000_0000;
            wave_reg <= ~wave_reg;
         end else begin
            half_reg <= half_reg + 32'h0000_0001;
         end
      end
   end
endmodule

/* rtl/hhclk_unit.sv */
// one modulo-n unit counter stage
`timescale 1ns/100ps
module hhclk_unit #(
   parameter logic [7:0] MAXV   = hhclk_pkg::SEC_MAX,
   parameter bit          STRICT = 1'b1
) (
   input  wire logic       clk,
   input  wire logic       rst_b,
   input  wire logic       chain_in,
   input  wire logic       setup_in,
   output logic [7:0]      count_reg,
   output logic            carry_reg
);
   logic inc_clk;
   logic inc_clk_d;
   logic at_max_reg;
   logic rise;
   logic fall;

   assign inc_clk = chain_in | setup_in;
   assign rise    = inc_clk & ~inc_clk_d;
   assign fall    = ~inc_clk & inc_clk_d;

   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         inc_clk_d <= 1'b0;
      end else begin
         inc_clk_d <= inc_clk;
      end
   end

   // max captured on falling edge; strict stages only
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         at_max_reg <= 1'b0;
      end else if (!STRICT || fall) begin
         at_max_reg <= (count_reg == MAXV);
      end
   end

   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         count_reg <= hhclk_pkg::COUNT_RESET;
      end else if (rise) begin
         if ((STRICT ? at_max_reg : 1'b0) || count_reg == MAXV) begin
            count_reg <= hhclk_pkg::COUNT_RESET;
         end else begin
            count_reg <= count_reg + 8'h01;
         end
      end
   end

   // clear doubles as carry level, held for one input high phase
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         carry_reg <= 1'b0;
      end else if (rise) begin
         carry_reg <= (count_reg == MAXV);
      end else if (fall) begin
         carry_reg <= 1'b0;
      end
   end

   a_wrap_zero: assert property (@(posedge clk) disable iff (!rst_b)
      (rise && count_reg == MAXV) |=> count_reg == hhclk_pkg::COUNT_RESET)
      else $error("stage did not wrap");
   a_hold_count: assert property (@(posedge clk) disable iff (!rst_b)
      !rise |=> $stable(count_reg))
      else $error("count changed without rising input");
   a_step_one: assert property (@(posedge clk) disable iff (!rst_b)
      (rise && count_reg < MAXV) |=> count_reg == $past(count_reg) + 8'h01)
      else $error("increment not by one");
   a_range_ok: assert property (@(posedge clk) disable iff (!rst_b)
      count_reg <= MAXV)
      else $error("count out of range");
endmodule

/* bench/hhclk_keys.sv */
// user key panel model that presses the four keys
`timescale 1ns/100ps
module hhclk_keys (
   input  wire logic clk,
   output logic      key_time_set,
   output logic      key_alarm_set,
   output logic      key_hour,
   output logic      key_minute
);
   initial begin
      key_time_set = 1'b0;
      key_alarm_set = 1'b0;
      key_hour = 1'b0;
      key_minute = 1'b0;
   end
   // four user keys
   // select is held across the key press and three cycles past its release
   task automatic press(input logic ts, input logic as, input logic hr, input int n);
      for (int i = 0; i < n; i++) begin
         @(negedge clk);
         key_time_set = ts;
         key_alarm_set = as;
         @(negedge clk);
         key_hour = hr;
         key_minute = !hr;
         repeat (2) @(negedge clk);
         key_hour = 1'b0;
         key_minute = 1'b0;
         repeat (3) @(negedge clk);
         key_time_set = 1'b0;
         key_alarm_set = 1'b0;
      end
   endtask
endmodule

/* bench/hhmm_clock_with_alarm_tb_top.sv */
// self-checking bench for the clock with alarm
`timescale 1ns/100ps
module hhmm_clock_with_alarm_tb_top;
   // short tick keeps a second at 200 cycles
   localparam int unsigned TICKS   = 2;
   localparam int unsigned SEC_CYC = 2 * hhclk_pkg::TICKS_PER_HALF * TICKS;
   logic       core_clk = 1'b0;
   logic       rst_b = 1'b0;
   logic       k_ts, k_as, k_hr, k_min;
   logic [7:0] seconds, minutes, hours, a_min, a_hr;
   logic       alarm;
   logic [7:0] e_min, e_hr, e_amin, e_ahr;
   int         errors = 0;
   int         total_checks = 0;
   int         cycles = 0;
   int         c;

   hhclk_top #(.TICK_CYCLES(TICKS)) hhclk_top_inst (.CORE_CLK(core_clk), .RST_B(rst_b),
      .KEY_TIME_SET(k_ts), .KEY_ALARM_SET(k_as), .KEY_HOUR(k_hr), .KEY_MINUTE(k_min),
      .SECONDS(seconds), .MINUTES(minutes), .HOURS(hours), .ALARM_MINUTES(a_min),
      .ALARM_HOURS(a_hr), .ALARM(alarm));
   hhclk_keys hhclk_keys_inst (.clk(core_clk), .key_time_set(k_ts), .key_alarm_set(k_as),
      .key_hour(k_hr), .key_minute(k_min));

   always #20 core_clk = ~core_clk;
   always @(posedge core_clk) begin
      cycles++;
      if (cycles == 60000) begin
         errors++;
         conclude();
      end
   end

   task automatic conclude();
      $display("checks %0d mismatches %0d", total_checks, errors);
      if (errors == 0 && total_checks > 0) $display("Finished cleanly");
      else $display("Finished with errors");
      $finish;
   endtask
   task automatic check8(input logic [7:0] got, input logic [7:0] exp);
      total_checks++;
      if (got !== exp) begin
         errors++;
         $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   function automatic logic [7:0] add(input logic [7:0] v, input int n, input int mx);
      return 8'((v + n) % (mx + 1));
   endfunction
   task automatic check_all();
      check8(minutes, e_min);
      check8(hours, e_hr);
      check8(a_min, e_amin);
      check8(a_hr, e_ahr);
   endtask
   // time select wins when both selects are held
   task automatic tpress(input logic ts, input logic as, input logic hr, input int n);
      hhclk_keys_inst.press(ts, as, hr, n);
      repeat (4) @(negedge core_clk);
      if (ts && hr) e_hr = add(e_hr, n, 23);
      else if (ts) begin
         e_hr = add(e_hr, (e_min + n) / 60, 23);
         e_min = add(e_min, n, 59);
      end else if (as && hr) e_ahr = add(e_ahr, n, 23);
      else if (as) e_amin = add(e_amin, n, 59);
   endtask
   task automatic wait_change(output int cnt);
      logic [7:0] s0;
      s0 = seconds;
      cnt = 0;
      while (seconds === s0 && cnt < 400) begin
         @(negedge core_clk);
         cnt++;
      end
   endtask

   initial begin
      void'($urandom(32'h4e40));
      {e_min, e_hr, e_amin, e_ahr} = 32'h0000_0000;
      repeat (3) @(negedge core_clk);
      rst_b = 1'b1;
      @(negedge core_clk);
      check8(seconds, 8'h00);
      check_all();
      check8({7'h00, alarm}, 8'h00);
      $display("test reset done");
      tpress(1'b0, 1'b0, 1'b1, 3);
      tpress(1'b0, 1'b0, 1'b0, 2);
      check_all();
      $display("test no select done");
      tpress(1'b1, 1'b0, 1'b1, $urandom_range(30, 1));
      tpress(1'b1, 1'b0, 1'b0, $urandom_range(70, 1));
      check_all();
      $display("test time setup done");
      tpress(1'b0, 1'b1, 1'b1, 25);
      tpress(1'b0, 1'b1, 1'b1, $urandom_range(22, 0));
      tpress(1'b0, 1'b1, 1'b0, $urandom_range(58, 1));
      check_all();
      tpress(1'b1, 1'b1, 1'b1, 1);
      check_all();
      $display("test alarm setup done");
      // minutes first: a minute wrap carries into hours, which are set after
      tpress(1'b1, 1'b0, 1'b0, (e_amin + 60 - e_min) % 60);
      tpress(1'b1, 1'b0, 1'b1, (e_ahr + 24 - e_hr) % 24);
      check_all();
      check8({7'h00, alarm}, 8'h01);
      tpress(1'b0, 1'b1, 1'b0, 1);
      check8({7'h00, alarm}, 8'h00);
      $display("test alarm match done");
      tpress(1'b1, 1'b0, 1'b1, (23 + 24 - e_hr) % 24);
      tpress(1'b1, 1'b0, 1'b0, (59 + 60 - e_min) % 60);
      check_all();
      wait_change(c);
      wait_change(c);
      check8(8'(c), 8'(SEC_CYC));
      c = 0;
      while (seconds !== 8'h00 && c < 13000) begin
         @(negedge core_clk);
         c++;
      end
      repeat (4) @(negedge core_clk);
      e_min = 8'h00;
      e_hr = 8'h00;
      check_all();
      $display("test chain carry done");
      tpress(1'b0, 1'b1, 1'b0, 61);
      check8(a_min, e_amin);
      rst_b = 1'b0;
      repeat (3) @(negedge core_clk);
      {e_min, e_hr, e_amin, e_ahr} = 32'h0000_0000;
      check_all();
      check8({7'h00, alarm}, 8'h00);
      rst_b = 1'b1;
      // 00:00 matches the cleared alarm, so the mask must keep the alarm low
      repeat (2) @(negedge core_clk);
      check_all();
      check8({7'h00, alarm}, 8'h00);
      $display("test second reset done");
      conclude();
   end
endmodule
